// File: rtl/aie_pkg.sv
// Package for the add-instruction execution unit.
// Assumes a 125 MHz core clock split into four phases per instruction cycle.
package aie_pkg;
    // ==========================================================
    // Instruction cycle phases
    localparam logic [1:0] Q1 = 2'h0;
    localparam logic [1:0] Q2 = 2'h1;
    localparam logic [1:0] Q3 = 2'h2;
    localparam logic [1:0] Q4 = 2'h3;
    // ==========================================================
    // Opcode patterns
    localparam logic [15:0] OP_NOP = 16'h0000;
    localparam logic [7:0] OP_ADD_LIT = 8'h0f;
    localparam logic [5:0] OP_ADD_FILE = 6'h09;
    localparam logic [4:0] OP_BRANCH = 5'h1a;
    localparam logic [7:0] OP_JUMP = 8'hef;
    localparam logic [3:0] OP_SECOND = 4'hf;
    // ==========================================================
    // Data space addresses and limits
    localparam logic [11:0] ADDR_PIN_IO = 12'hf80;
    localparam logic [11:0] ADDR_TIMER_COUNT = 12'hf90;
    localparam logic [7:0] ACCESS_SPLIT = 8'h80;
    localparam logic [3:0] ACCESS_HIGH_BANK = 4'hf;
    localparam logic [7:0] INDEX_LIMIT = 8'h5f;
    // ==========================================================
    // Software register offsets
    localparam logic [7:0] REG_CTRL = 8'h00;
    localparam logic [7:0] REG_INDEX = 8'h04;
    localparam logic [7:0] REG_STATUS = 8'h08;
    localparam logic [7:0] REG_ACCUM = 8'h0c;
    localparam logic [7:0] REG_PC = 8'h10;
    localparam logic [7:0] REG_BANK = 8'h14;
    // ==========================================================
    // Control bit positions and reset values
    localparam int CTRL_RUN = 0;
    localparam int CTRL_EXT = 1;
    localparam int CTRL_PRESC = 2;
    localparam logic [2:0] CTRL_RESET = 3'h0;
    localparam logic [15:0] PC_RESET = 16'h0000;
    // ==========================================================
    // Status flag positions: N, OV, Z, DC, C.
    localparam int FLAG_C = 0;
    localparam int FLAG_DC = 1;
    localparam int FLAG_Z = 2;
    localparam int FLAG_OV = 3;
    localparam int FLAG_N = 4;
endpackage : aie_pkg

// File: rtl/aie_add_if.sv
// Interface carrying operands, sum and flags between core and adder.
// Assumes both ends sit in the core clock domain.
`timescale 1ns/1ns
interface aie_add_if;
    logic [7:0] a;
    logic [7:0] b;
    logic [7:0] sum;
    logic [4:0] flags;
    modport core (output a, output b, input sum, input flags);
    modport adder (input a, input b, output sum, output flags);
endinterface : aie_add_if

// File: rtl/aie_adder.sv
// Eight-bit adder producing the five arithmetic status flags.
// Assumes purely combinational use inside one phase.
`timescale 1ns/1ns
module aie_adder (
    aie_add_if.adder add
);
    import aie_pkg::*;
    logic [8:0] full;
    logic [4:0] low;
    // Sum with carry out and nibble carry for the digit flag.
    assign full = {1'b0, add.a} + {1'b0, add.b};
    assign low = {1'b0, add.a[3:0]} + {1'b0, add.b[3:0]};
    assign add.sum = full[7:0];
    // Flag set from the eight-bit result.
    assign add.flags[FLAG_C] = full[8];
    assign add.flags[FLAG_DC] = low[4];
    assign add.flags[FLAG_Z] = (full[7:0] == 8'h00);
    assign add.flags[FLAG_OV] = (add.a[7] == add.b[7]) &&
                                (full[7] != add.a[7]);
    assign add.flags[FLAG_N] = full[7];
endmodule : aie_adder

// File: rtl/aie_resolve.sv
// Operand address resolution for the file-register add form.
// Assumes bank and index base are stable during an instruction cycle.
`timescale 1ns/1ns
module aie_resolve (
    input wire logic [7:0] file_i,
    input wire logic access_i,
    input wire logic ext_en_i,
    input wire logic [3:0] bank_i,
    input wire logic [11:0] index_i,
    output logic [11:0] addr_o
);
    import aie_pkg::*;
    // Pick indexed, access-bank or bank-selected addressing.
    always_comb begin
        if (access_i) begin
            addr_o = {bank_i, file_i};
        end else if (ext_en_i && file_i <= INDEX_LIMIT) begin
            addr_o = index_i + {4'h0, file_i};
        end else if (file_i < ACCESS_SPLIT) begin
            addr_o = {4'h0, file_i};
        end else begin
            addr_o = {ACCESS_HIGH_BANK, file_i};
        end
    end
endmodule : aie_resolve

// File: rtl/aie_core.sv
// Execution unit for the two add instructions plus the general execution
// behaviour: pin reads on read-modify-write, timer prescaler clear, branch
// bubble and two-word handling.
// Assumes program memory answers combinationally to prog_addr_o and data
// memory returns read data in the cycle after data_rd_o.
//
// The implementer's own choices: the register addresses and strobed register access.
`timescale 1ns/1ns
module aie_core (
    input wire logic core_clk_i,
    input wire logic rst_i,
    input wire logic [7:0] reg_addr_i,
    input wire logic [15:0] reg_wdata_i,
    input wire logic reg_wr_i,
    input wire logic reg_rd_i,
    output logic [15:0] reg_rdata_o,
    output logic [15:0] prog_addr_o,
    input wire logic [15:0] prog_data_i,
    output logic [11:0] data_addr_o,
    output logic data_rd_o,
    input wire logic [7:0] data_rdata_i,
    output logic data_wr_o,
    output logic [7:0] data_wdata_o,
    input wire logic [7:0] pins_i,
    output logic prescaler_clr_o
);
    import aie_pkg::*;

    // ==========================================================
    // State
    logic [1:0] q_r;
    logic [2:0] ctrl_r;
    logic [11:0] index_r;
    logic [3:0] bank_select_register_r;
    logic [7:0] accum_r;
    logic [4:0] flags_r;
    logic [15:0] pc_r;
    logic [15:0] ir_r;
    logic flush_r;
    logic consume_r;
    logic [7:0] jump_lo_r;
    logic [7:0] operand_r;
    logic [7:0] sum_r;
    logic [4:0] sum_flags_r;
    logic [11:0] addr_r;
    logic run;
    logic is_lit;
    logic is_file;
    logic is_branch;
    logic is_jump;
    logic [11:0] res_addr;
    logic [15:0] branch_target;

    aie_add_if add ();

    aie_adder u_adder (
        .add(add)
    );

    aie_resolve u_resolve (
        .file_i(ir_r[7:0]),
        .access_i(ir_r[8]),
        .ext_en_i(ctrl_r[CTRL_EXT]),
        .bank_i(bank_select_register_r),
        .index_i(index_r),
        .addr_o(res_addr)
    );

    // ==========================================================
    // Decode
    // A consumed second word never decodes as an instruction of its own.
    assign run = ctrl_r[CTRL_RUN];
    assign is_lit = !consume_r && ir_r[15:8] == OP_ADD_LIT;
    assign is_file = !consume_r && ir_r[15:10] == OP_ADD_FILE;
    assign is_branch = !consume_r && ir_r[15:11] == OP_BRANCH;
    assign is_jump = !consume_r && ir_r[15:8] == OP_JUMP;
    assign branch_target = pc_r + {{5{ir_r[10]}}, ir_r[10:0]};
    // Adder inputs: accumulator and literal or fetched operand.
    assign add.a = accum_r;
    assign add.b = is_lit ? ir_r[7:0] : operand_r;

    // ==========================================================
    // Phase divider
    // Four-phase counter; each value is a one-cycle phase enable.
    always_ff @(posedge core_clk_i or posedge rst_i) begin
        if (rst_i) begin
            q_r <= Q1;
        end else if (run) begin
            q_r <= q_r + 2'h1;
        end
    end

    // ==========================================================
    // Software registers
    // Control, index base and bank select written over the plain port.
    always_ff @(posedge core_clk_i or posedge rst_i) begin
        if (rst_i) begin
            ctrl_r <= CTRL_RESET;
            index_r <= 12'h000;
            bank_select_register_r <= 4'h0;
        end else if (reg_wr_i) begin
            if (reg_addr_i == REG_CTRL) begin
                ctrl_r <= reg_wdata_i[2:0];
            end
            if (reg_addr_i == REG_INDEX) begin
                index_r <= reg_wdata_i[11:0];
            end
            if (reg_addr_i == REG_BANK) begin
                bank_select_register_r <= reg_wdata_i[3:0];
            end
        end
    end

    // Read data one cycle after the strobe; unmapped offsets read zero.
    always_ff @(posedge core_clk_i or posedge rst_i) begin
        if (rst_i) begin
            reg_rdata_o <= 16'h0000;
        end else if (reg_rd_i) begin
            unique case (reg_addr_i)
                REG_CTRL: reg_rdata_o <= {13'h0000, ctrl_r};
                REG_INDEX: reg_rdata_o <= {4'h0, index_r};
                REG_STATUS: reg_rdata_o <= {11'h000, flags_r};
                REG_ACCUM: reg_rdata_o <= {8'h00, accum_r};
                REG_PC: reg_rdata_o <= pc_r;
                REG_BANK: reg_rdata_o <= {12'h000, bank_select_register_r};
                default: reg_rdata_o <= 16'h0000;
            endcase
        end else begin
            reg_rdata_o <= 16'h0000;
        end
    end

    // ==========================================================
    // Fetch and program counter
    // branch bubble
    always_ff @(posedge core_clk_i or posedge rst_i) begin
        if (rst_i) begin
            pc_r <= PC_RESET;
            ir_r <= OP_NOP;
            flush_r <= 1'b0;
            consume_r <= 1'b0;
            jump_lo_r <= 8'h00;
        end else if (run && q_r == Q1) begin
            if (is_branch) begin
                pc_r <= branch_target;
                flush_r <= 1'b1;
            end
            if (consume_r) begin
                pc_r <= {ir_r[7:0], jump_lo_r};
            end
        end else if (run && q_r == Q4) begin
            consume_r <= is_jump;
            jump_lo_r <= ir_r[7:0];
            if (flush_r) begin
                ir_r <= OP_NOP;
                flush_r <= 1'b0;
            end else begin
                ir_r <= prog_data_i;
                pc_r <= pc_r + 16'h0001;
            end
        end
    end
    assign prog_addr_o = pc_r;

    // ==========================================================
    // Operand fetch
    // access bank
    always_ff @(posedge core_clk_i or posedge rst_i) begin
        if (rst_i) begin
            addr_r <= 12'h000;
            data_rd_o <= 1'b0;
        end else begin
            data_rd_o <= run && q_r == Q1 && is_file;
            if (run && q_r == Q1 && is_file) begin
                addr_r <= res_addr;
            end
        end
    end
    assign data_addr_o = addr_r;

    always_ff @(posedge core_clk_i or posedge rst_i) begin
        if (rst_i) begin
            operand_r <= 8'h00;
        end else if (run && q_r == Q3 && is_file) begin
            operand_r <= (addr_r == ADDR_PIN_IO) ? pins_i : data_rdata_i;
        end
    end

    // Sum and flags captured at the end of the process phase.
    always_ff @(posedge core_clk_i or posedge rst_i) begin
        if (rst_i) begin
            sum_r <= 8'h00;
            sum_flags_r <= 5'h00;
        end else if (run && q_r == Q4) begin
            sum_r <= add.sum;
            sum_flags_r <= add.flags;
        end
    end

    // ==========================================================
    // Write-back (first phase of the following instruction cycle)
    logic wb_lit_r;
    logic wb_file_r;
    logic wb_dest_r;
    always_ff @(posedge core_clk_i or posedge rst_i) begin
        if (rst_i) begin
            wb_lit_r <= 1'b0;
            wb_file_r <= 1'b0;
            wb_dest_r <= 1'b0;
        end else begin
            wb_lit_r <= run && q_r == Q4 && is_lit;
            wb_file_r <= run && q_r == Q4 && is_file;
            wb_dest_r <= ir_r[9];
        end
    end

    always_ff @(posedge core_clk_i or posedge rst_i) begin
        if (rst_i) begin
            accum_r <= 8'h00;
            flags_r <= 5'h00;
        end else begin
            if (wb_lit_r || (wb_file_r && !wb_dest_r)) begin
                accum_r <= sum_r;
            end else if (reg_wr_i && reg_addr_i == REG_ACCUM) begin
                accum_r <= reg_wdata_i[7:0];
            end
            if (wb_lit_r || wb_file_r) begin
                flags_r <= sum_flags_r;
            end
        end
    end

    // The write pulse stands in the next first phase, while the operand
    // address still holds and before the next read, so a following add on
    // the same place sees the new value.
    // sum to file
    always_ff @(posedge core_clk_i or posedge rst_i) begin
        if (rst_i) begin
            data_wr_o <= 1'b0;
            data_wdata_o <= 8'h00;
            prescaler_clr_o <= 1'b0;
        end else begin
            data_wr_o <= run && q_r == Q4 && is_file && ir_r[9];
            prescaler_clr_o <= run && q_r == Q4 && is_file && ir_r[9] &&
                               addr_r == ADDR_TIMER_COUNT &&
                               ctrl_r[CTRL_PRESC];
            if (run && q_r == Q4 && is_file && ir_r[9]) begin
                data_wdata_o <= add.sum;
            end
        end
    end

    // ==========================================================
    // Assertions
    chk_pin_operand: assert property (
        @(posedge core_clk_i) disable iff (rst_i)
        (run && q_r == Q3 && is_file && addr_r == ADDR_PIN_IO)
        |=> operand_r == $past(pins_i))
        else $error("Pin operand not taken from pins.");

    chk_presc_clear: assert property (
        @(posedge core_clk_i) disable iff (rst_i)
        (run && q_r == Q4 && is_file && ir_r[9] &&
         addr_r == ADDR_TIMER_COUNT && ctrl_r[CTRL_PRESC])
        |=> prescaler_clr_o && data_wr_o)
        else $error("Prescaler not cleared on timer write.");

    chk_presc_quiet: assert property (
        @(posedge core_clk_i) disable iff (rst_i)
        prescaler_clr_o |-> $past(ctrl_r[CTRL_PRESC]) && data_wr_o &&
        data_addr_o == ADDR_TIMER_COUNT)
        else $error("Prescaler cleared without cause.");

    chk_branch_bubble: assert property (
        @(posedge core_clk_i) disable iff (rst_i)
        (run && q_r == Q1 && is_branch) ##1 run [*3]
        |=> ir_r == OP_NOP && !flush_r)
        else $error("Branch did not insert a NOP cycle.");

    chk_second_word: assert property (
        @(posedge core_clk_i) disable iff (rst_i)
        (run && q_r == Q1 && ir_r[15:12] == OP_SECOND && !consume_r)
        |-> !is_lit && !is_file && !is_branch && !is_jump
        ##1 !data_rd_o [*4])
        else $error("Second word executed as an instruction.");

    chk_sum_accum: assert property (
        @(posedge core_clk_i) disable iff (rst_i)
        (wb_file_r && !wb_dest_r) |=> accum_r == $past(sum_r) && !data_wr_o)
        else $error("Sum not placed in accumulator.");

    chk_sum_file: assert property (
        @(posedge core_clk_i) disable iff (rst_i)
        (wb_file_r && wb_dest_r)
        |-> data_wr_o && data_wdata_o == sum_r
        ##1 accum_r == $past(accum_r))
        else $error("Sum not written back to file.");

    chk_access_bank: assert property (
        @(posedge core_clk_i) disable iff (rst_i)
        (run && q_r == Q1 && is_file && !ir_r[8] &&
         !(ctrl_r[CTRL_EXT] && ir_r[7:0] <= INDEX_LIMIT))
        |=> data_rd_o && data_addr_o[11:8] ==
            (ir_r[7] ? ACCESS_HIGH_BANK : 4'h0))
        else $error("Access bank address wrong.");

    chk_bank_select: assert property (
        @(posedge core_clk_i) disable iff (rst_i)
        (run && q_r == Q1 && is_file && ir_r[8])
        |=> data_addr_o == {$past(bank_select_register_r), $past(ir_r[7:0])})
        else $error("Bank select not applied.");

    chk_indexed: assert property (
        @(posedge core_clk_i) disable iff (rst_i)
        (run && q_r == Q1 && is_file && !ir_r[8] && ctrl_r[CTRL_EXT] &&
         ir_r[7:0] <= INDEX_LIMIT)
        |=> data_addr_o == $past(index_r) + {4'h0, $past(ir_r[7:0])})
        else $error("Indexed offset address wrong.");

    chk_lit_add: assert property (
        @(posedge core_clk_i) disable iff (rst_i)
        (run && q_r == Q4 && is_lit && !(reg_wr_i))
        |=> ##1 accum_r == $past(accum_r, 2) + $past(ir_r[7:0], 2))
        else $error("Literal add result wrong.");

    chk_flags_zero: assert property (
        @(posedge core_clk_i) disable iff (rst_i)
        (wb_lit_r || wb_file_r)
        |=> flags_r[FLAG_Z] == ($past(sum_r) == 8'h00) &&
            flags_r[FLAG_N] == $past(sum_r[7]))
        else $error("Zero or negative flag wrong.");

    cov_lit: cover property (@(posedge core_clk_i) wb_lit_r);
    cov_file_wb: cover property (@(posedge core_clk_i) data_wr_o);
    cov_branch: cover property (@(posedge core_clk_i) flush_r);
    cov_jump: cover property (@(posedge core_clk_i) consume_r && q_r == Q1);
endmodule : aie_core

// File: tb/tb_add_instruction_execute.sv
// Self-checking testbench for the add-instruction execution unit.
// Assumes aie_core with a program memory answering combinationally and a
// data memory answering in the cycle after each read pulse.
`timescale 1ns/1ns
module tb_add_instruction_execute;
    import aie_pkg::*;
    // ==========================================================
    // Signals and bench state
    typedef struct {logic [11:0] a; logic [7:0] d; logic p;} aie_wr_t;
    logic core_clk_i = 1'b0;
    logic rst_i = 1'b1;
    logic [7:0] reg_addr_i = 8'h00;
    logic [15:0] reg_wdata_i = 16'h0000;
    logic reg_wr_i = 1'b0;
    logic reg_rd_i = 1'b0;
    logic [15:0] reg_rdata_o, prog_addr_o, prog_data_i;
    logic [11:0] data_addr_o;
    logic data_rd_o, data_wr_o, prescaler_clr_o;
    logic [7:0] data_rdata_i = 8'h00;
    logic [7:0] data_wdata_o;
    logic [7:0] pins_i = 8'h00;
    logic [15:0] pmem [0:63];
    logic [7:0] dmem [0:4095];
    logic [7:0] zero_regs [5] = '{REG_CTRL, REG_STATUS, REG_ACCUM, REG_PC,
                                  8'h30};
    aie_wr_t wq[$];
    aie_wr_t w;
    logic [15:0] rq[$];
    logic rd_d = 1'b0;
    logic [7:0] acc, pv;
    logic [4:0] flg;
    logic presc;
    int pc_b;
    int seed = 27;
    int num_errors = 0;
    int check_count = 0;

    // Clock of 8 ns period.
    initial begin
        forever #4 core_clk_i = ~core_clk_i;
    end

    aie_core dut (
        .core_clk_i(core_clk_i), .rst_i(rst_i), .reg_addr_i(reg_addr_i),
        .reg_wdata_i(reg_wdata_i), .reg_wr_i(reg_wr_i),
        .reg_rd_i(reg_rd_i), .reg_rdata_o(reg_rdata_o),
        .prog_addr_o(prog_addr_o), .prog_data_i(prog_data_i),
        .data_addr_o(data_addr_o), .data_rd_o(data_rd_o),
        .data_rdata_i(data_rdata_i), .data_wr_o(data_wr_o),
        .data_wdata_o(data_wdata_o), .pins_i(pins_i),
        .prescaler_clr_o(prescaler_clr_o)
    );

    // ==========================================================
    // Memories facing the core
    // Program words beyond the table read as no-operation.
    assign prog_data_i = (prog_addr_o < 16'h0040) ? pmem[prog_addr_o[5:0]]
                                                  : OP_NOP;

    // Read data stand one cycle only; otherwise the bus keeps changing.
    always @(posedge core_clk_i) begin
        data_rdata_i <= (data_rd_o === 1'b1) ? dmem[data_addr_o]
                                             : ~data_rdata_i;
        if (data_wr_o === 1'b1) begin
            dmem[data_addr_o] <= data_wdata_o;
        end
    end

    // ==========================================================
    // Result monitor and verdict
    task automatic fail(input string msg);
        num_errors++;
        $display("CHECK FAILED at %0t: %s", $time, msg);
    endtask : fail

    task automatic tally_and_finish;
        if (num_errors == 0 && check_count > 0) begin
            $display("Result: passed");
        end else begin
            $display("Result: failed");
        end
        $finish;
    endtask : tally_and_finish

    // Each write pulse or read answer is matched with the oldest note.
    always @(posedge core_clk_i) begin
        if (data_wr_o === 1'b1) begin
            check_count++;
            if (wq.size() == 0) begin
                fail("unexpected data write");
            end else begin
                w = wq.pop_front();
                if ({data_addr_o, data_wdata_o, prescaler_clr_o} !==
                    {w.a, w.d, w.p}) fail("data write wrong");
            end
        end else if (prescaler_clr_o !== 1'b0) begin
            fail("prescaler clear without write");
        end
        if (rd_d) begin
            check_count++;
            if (reg_rdata_o !== rq.pop_front()) fail("read wrong");
        end
        rd_d <= (reg_rd_i === 1'b1);
    end

    // ==========================================================
    // Register bus, program building and reference model
    task automatic reg_write(input logic [7:0] a, input logic [15:0] d);
        @(posedge core_clk_i);
        reg_addr_i <= a;
        reg_wdata_i <= d;
        reg_wr_i <= 1'b1;
        @(posedge core_clk_i);
        reg_wr_i <= 1'b0;
    endtask : reg_write

    task automatic reg_read(input logic [7:0] a, input logic [15:0] e);
        rq.push_back(e);
        @(posedge core_clk_i);
        reg_addr_i <= a;
        reg_rd_i <= 1'b1;
        @(posedge core_clk_i);
        reg_rd_i <= 1'b0;
    endtask : reg_read

    task automatic put(input logic [15:0] word);
        pmem[pc_b] = word;
        pc_b++;
    endtask : put

    // Sum and the five flags of an 8-bit add to the accumulator.
    task automatic add_model(input logic [7:0] b, output logic [7:0] s);
        logic [8:0] t;
        t = {1'b0, acc} + {1'b0, b};
        s = t[7:0];
        flg[FLAG_C] = t[8];
        flg[FLAG_DC] = ({1'b0, acc[3:0]} + {1'b0, b[3:0]}) > 5'h0f;
        flg[FLAG_Z] = (t[7:0] == 8'h00);
        flg[FLAG_OV] = (acc[7] == b[7]) && (t[7] != acc[7]);
        flg[FLAG_N] = t[7];
    endtask : add_model

    task automatic add_lit(input logic [7:0] k);
        put({OP_ADD_LIT, k});
        add_model(k, acc);
    endtask : add_lit

    // The pin register reads the pins, every other place its memory.
    task automatic add_file(input logic [7:0] f, input logic d,
                            input logic a, input logic [11:0] ad);
        logic [7:0] s;
        put({OP_ADD_FILE, d, a, f});
        add_model((ad == ADDR_PIN_IO) ? pv : dmem[ad], s);
        if (d) begin
            wq.push_back('{ad, s, presc && (ad == ADDR_TIMER_COUNT)});
        end else begin
            acc = s;
        end
    endtask : add_file

    task automatic do_reset;
        rst_i <= 1'b1;
        repeat (3) @(posedge core_clk_i);
        rst_i <= 1'b0;
        pc_b = 0;
        acc = 8'h00;
        flg = 5'h00;
        foreach (pmem[i]) pmem[i] = OP_NOP;
    endtask : do_reset

    // Ends the program in a branch to itself, runs it, then checks.
    task automatic run_prog(input logic [15:0] ctrl);
        int n;
        put({OP_BRANCH, 11'h7ff});
        reg_write(REG_CTRL, ctrl);
        n = 0;
        while (prog_addr_o !== 16'(pc_b - 1) && n < 400) begin
            @(posedge core_clk_i);
            n++;
        end
        if (n == 400) fail("program never reached its end");
        repeat (16) @(posedge core_clk_i);
        reg_write(REG_CTRL, 16'h0000);
        reg_read(REG_ACCUM, {8'h00, acc});
        reg_read(REG_STATUS, {11'h000, flg});
        repeat (2) @(posedge core_clk_i);
        check_count++;
        if (wq.size() != 0) fail("data writes missing");
    endtask : run_prog

    // ==========================================================
    // Main sequence
    initial begin
        pv = 8'($random(seed));
        foreach (dmem[i]) dmem[i] = 8'($random(seed));
        dmem[ADDR_PIN_IO] = ~pv;
        do_reset();
        pins_i <= pv;
        foreach (zero_regs[i]) reg_read(zero_regs[i], 16'h0000);
        // Banked, access, pin, timer and accumulator forms, then flow.
        reg_write(REG_BANK, 16'h0003);
        reg_read(REG_BANK, 16'h0003);
        presc = 1'b1;
        add_lit(8'h15);
        add_file(8'h20, 1'b1, 1'b1, 12'h320);
        add_file(8'h30, 1'b1, 1'b0, 12'h030);
        add_file(8'h80, 1'b1, 1'b0, ADDR_PIN_IO);
        add_file(8'h90, 1'b1, 1'b0, ADDR_TIMER_COUNT);
        add_file(8'h40, 1'b0, 1'b1, 12'h340);
        put({OP_BRANCH, 11'h001});
        put({OP_ADD_LIT, 8'hff});
        put({OP_JUMP, 8'h0b});
        put({OP_SECOND, 12'h000});
        put({OP_ADD_LIT, 8'h01});
        put({OP_SECOND, 12'h0ff});
        add_lit(8'($random(seed)));
        run_prog(16'h0005);
        // Extended set: indexed offsets up to the limit, then access bank.
        do_reset();
        reg_write(REG_INDEX, 16'h0200);
        reg_read(REG_INDEX, 16'h0200);
        reg_write(REG_BANK, 16'h0005);
        reg_write(REG_ACCUM, {8'h00, pv});
        acc = pv;
        reg_read(REG_ACCUM, {8'h00, pv});
        presc = 1'b0;
        add_file(8'h10, 1'b1, 1'b0, 12'h210);
        add_file(INDEX_LIMIT, 1'b1, 1'b0, 12'h25f);
        add_file(8'h60, 1'b1, 1'b0, 12'h060);
        add_file(8'h90, 1'b1, 1'b0, ADDR_TIMER_COUNT);
        dmem[12'h520] = 8'h00 - acc;
        add_file(8'h20, 1'b0, 1'b1, 12'h520);
        run_prog(16'h0003);
        tally_and_finish();
    end

    // Watchdog: the tests need well under a thousand cycles.
    initial begin
        repeat (5000) @(posedge core_clk_i);
        num_errors++;
        tally_and_finish();
    end
endmodule : tb_add_instruction_execute
